//--- verilog/bus_talker_output_sequencer.sv
// Purpose: Talker output sequencing and DAV handshake for the bus.
// Assumes: Bus and sequencer inputs synchronous to mclk_i.
// Notes: Registers over AHB-Lite give bank select and live status.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module bus_talker_output_sequencer #(
    parameter int qual_delay_cyc_p = talker_pkg::qual_delay_cyc
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic power_up_clear_n_i,
    input wire talker_pkg::bus_in_s bus_i,
    output talker_pkg::bus_out_s bus_o,
    input wire talker_pkg::seq_in_s seq_i,
    output talker_pkg::qual_s qual_o,
    input wire talker_pkg::status_lines_s status_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o
);

    ////////////////////////////////////////////////////////////////////
    // Parameter checks.

    // A zero-length delay line cannot be built.
    initial
    begin
        if (qual_delay_cyc_p < 1)
        begin
            $error("qual_delay_cyc_p must be at least one");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Declarations.

    logic output_enable_a;
    logic output_enable_b;
    logic ready_qualifier;
    logic accepted_qualifier;
    logic transfer_done_qualifier;
    logic data_valid_ff_out_q;
    logic data_valid_ff_out_d;
    logic data_valid_ff_out_n;
    logic word_counter_clear;
    logic advance_counter;
    logic [3:0] word_count_q;
    logic [3:0] word_count_d;
    logic rom_bank_select;
    logic [4:0] rom_addr;
    logic [7:0] rom_out;
    logic [7:1] word_now;
    logic [7:1] word_q;
    logic [qual_delay_cyc_p-1:0] ready_pipe_q;
    logic [qual_delay_cyc_p-1:0] accept_pipe_q;
    logic ready_qualifier_delayed;
    logic accepted_qualifier_delayed;
    logic [31:0] ctrl_q;
    logic [31:0] status_word;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic addr_phase;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////
    // Talk transfer control gates.

    // Enables open only when talk addressed and the bus in data mode.
    assign output_enable_a = ~bus_i.talk_addressed_n
                           & ~bus_i.bus_attention_in;
    assign output_enable_b = output_enable_a;

    ////////////////////////////////////////////////////////////////////
    // Data valid status generator.

    // Ready needs enable b and listeners ready; either low forces it low.
    assign ready_qualifier = output_enable_b
                           & bus_i.ready_for_data;

    // Accepted follows the bus accepted line directly, without enable gating.
    assign accepted_qualifier = bus_i.data_accepted;

    // Settling delay lines; listeners glitch briefly after a change.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ready_pipe_q <= '0;
            accept_pipe_q <= '0;
        end
        else
        begin
            // The oldest sample falls off the top on purpose.
            ready_pipe_q <= qual_delay_cyc_p'({ready_pipe_q,
                                              ready_qualifier});
            accept_pipe_q <= qual_delay_cyc_p'({accept_pipe_q,
                                               accepted_qualifier});
        end
    end

    assign ready_qualifier_delayed = ready_pipe_q[qual_delay_cyc_p-1];
    assign accepted_qualifier_delayed = accept_pipe_q[qual_delay_cyc_p-1];

    // JK flop. A set toggle counts only with delayed ready high and delayed
    // accepted low, the condition the sequencer already checks before it sends one; a
    // reset toggle is always honoured so the bus is never held.
    always_comb
    begin
        data_valid_ff_out_d = data_valid_ff_out_q;
        if (!power_up_clear_n_i)
        begin
            data_valid_ff_out_d = 1'b0;
        end
        else if (seq_i.toggle_data_valid_instr)
        begin
            if (data_valid_ff_out_q)
            begin
                data_valid_ff_out_d = 1'b0;
            end
            else if (ready_qualifier_delayed
                     && !accepted_qualifier_delayed)
            begin
                data_valid_ff_out_d = 1'b1;
            end
        end
    end

    // Flop storage.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            data_valid_ff_out_q <= 1'b0;
        end
        else
        begin
            data_valid_ff_out_q <= data_valid_ff_out_d;
        end
    end

    assign data_valid_ff_out_n = ~data_valid_ff_out_q;

    ////////////////////////////////////////////////////////////////////
    // Word counter.

    // Rising edge of the inverted flop output, seen one cycle early.
    assign advance_counter = data_valid_ff_out_q
                           & ~data_valid_ff_out_d;
    assign word_counter_clear = seq_i.cycle_start_clear_instr;

    // Clear wins over an advance in the same cycle; the count stops at
    // the done address so a stray toggle cannot wrap to word zero.
    always_comb
    begin
        word_count_d = word_count_q;
        if (word_counter_clear)
        begin
            word_count_d = 4'h0;
        end
        else if (advance_counter
                 && word_count_q < 4'(talker_pkg::word_count))
        begin
            word_count_d = word_count_q + 4'h1;
        end
    end

    // Counter storage.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            word_count_q <= 4'h0;
        end
        else
        begin
            word_count_q <= word_count_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ROM, line selectors and output gates.

    assign rom_bank_select = ctrl_q[talker_pkg::ctrl_bank_bit];
    assign rom_addr = {rom_bank_select, word_count_q};

    talker_char_rom #(
        .table_p(talker_pkg::char_rom_default)
    ) u_rom (
        .addr_i(rom_addr),
        .status_lines_i(status_i),
        .rom_o(rom_out),
        .word_o(word_now)
    );

    // Done once both Y0 and Y7 are low; held until the counter clears.
    assign transfer_done_qualifier = ~rom_out[0] & ~rom_out[7];

    // Word register keeps the data pins free of ROM decode glitches.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            word_q <= 7'h00;
        end
        else
        begin
            word_q <= word_now;
        end
    end

    // Bus pins: data while both enables high, DAV pulled low when set.
    always_comb
    begin
        bus_o.data = word_q;
        bus_o.data_oe = output_enable_a & output_enable_b;
        bus_o.dav = 1'b0;
        bus_o.dav_oe = data_valid_ff_out_q & output_enable_b;
    end

    // Qualifier multiplexer presents every qualifier inverted.
    always_comb
    begin
        qual_o.ready_qualifier_delayed_n =
            ~ready_qualifier_delayed;
        qual_o.accepted_qualifier_delayed_n =
            ~accepted_qualifier_delayed;
        qual_o.transfer_done_qualifier_n =
            ~transfer_done_qualifier;
    end

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite register slave.

    // Zero wait state slave with an always OKAY response.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign addr_phase = hsel_i & hready_i & htrans_i[1];

    // Live status picture of the handshake.
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[talker_pkg::st_count_lsb +: 4] = word_count_q;
        status_word[talker_pkg::st_dav_bit] = data_valid_ff_out_q;
        status_word[talker_pkg::st_ready_bit] = ready_qualifier_delayed;
        status_word[talker_pkg::st_accept_bit] =
            accepted_qualifier_delayed;
        status_word[talker_pkg::st_done_bit] = transfer_done_qualifier;
        status_word[talker_pkg::st_oe_a_bit] = output_enable_a;
        status_word[talker_pkg::st_oe_b_bit] = output_enable_b;
        status_word[talker_pkg::st_bank_bit] = rom_bank_select;
    end

    // Write address phase capture; data follows one cycle later.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= addr_phase & hwrite_i;
            wr_addr_q <= haddr_i[7:0];
        end
    end

    // Control register; only the bank select bit is writable.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_q <= talker_pkg::ctrl_reset;
        end
        else if (wr_pend_q && wr_addr_q == talker_pkg::ctrl_addr)
        begin
            ctrl_q <= {31'h0000_0000,
                       hwdata_i[talker_pkg::ctrl_bank_bit]};
        end
    end

    // Read data is latched in the address phase; unmapped reads zero.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (addr_phase && !hwrite_i)
        begin
            case (haddr_i[7:0])
                talker_pkg::ctrl_addr: rdata_q <= ctrl_q;
                talker_pkg::status_addr: rdata_q <= status_word;
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata_o = rdata_q;

endmodule
`default_nettype wire

//--- verilog/talker_pkg.sv
// Purpose: Shared constants and carriers for the talker output sequencer.
// Assumes: One 200 MHz clock; AHB-Lite register access.
// Notes: Character table defaults live here so the ROM stays generic.
package talker_pkg;

    // Register map, byte addresses of aligned words.
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] status_addr = 8'h04;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam int ctrl_bank_bit = 0;

    // Status register field positions.
    localparam int st_count_lsb = 0;
    localparam int st_dav_bit = 4;
    localparam int st_ready_bit = 5;
    localparam int st_accept_bit = 6;
    localparam int st_done_bit = 7;
    localparam int st_oe_a_bit = 8;
    localparam int st_oe_b_bit = 9;
    localparam int st_bank_bit = 10;

    // Handshake sequencing figures.
    localparam int word_count = 14;
    localparam int clk_period_ps = 5000;
    localparam int qual_delay_ns = 50;
    localparam int qual_delay_cyc =
        (qual_delay_ns * 1000 + clk_period_ps - 1) / clk_period_ps;

    // AHB transfer type for a new single transfer.
    localparam logic [1:0] htrans_nonseq = 2'h2;

    // Character ROM: index is {bank, counter}; value is Y7..Y0.
    localparam logic [31:0][7:0] char_rom_default = '{
        8'h00, 8'h00, 8'hb0, 8'hb0, 8'hb0, 8'hb0, 8'hb0, 8'hb0,
        8'hb0, 8'hb0, 8'hb0, 8'h37, 8'haf, 8'h45, 8'h43, 8'h51,
        8'h00, 8'h00, 8'hb0, 8'hb0, 8'hb0, 8'hb0, 8'hb0, 8'hb0,
        8'hb0, 8'hb0, 8'hb0, 8'h37, 8'ha2, 8'h45, 8'h43, 8'h51
    };

    typedef struct packed {
        logic talk_addressed_n;
        logic bus_attention_in;
        logic ready_for_data;
        logic data_accepted;
    } bus_in_s;

    typedef struct packed {
        logic [7:1] data;
        logic data_oe;
        logic dav;
        logic dav_oe;
    } bus_out_s;

    typedef struct packed {
        logic toggle_data_valid_instr;
        logic cycle_start_clear_instr;
    } seq_in_s;

    typedef struct packed {
        logic ready_qualifier_delayed_n;
        logic accepted_qualifier_delayed_n;
        logic transfer_done_qualifier_n;
    } qual_s;

    typedef struct packed {
        logic [11:0] other_status;
        logic fourth_status;
        logic mode_bit_three;
        logic under_range_status;
        logic over_range_status;
    } status_lines_s;

endpackage

//--- verilog/talker_char_rom.sv
// Purpose: Character ROM plus line selectors forming one data word.
// Assumes: Table given as a parameter; status lines synchronous.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module talker_char_rom #(
    parameter logic [31:0][7:0] table_p = talker_pkg::char_rom_default
) (
    input wire logic [4:0] addr_i,
    input wire logic [15:0] status_lines_i,
    output logic [7:0] rom_o,
    output logic [7:1] word_o
);

    logic [3:0] selected;

    // Table lookup; the contents are defined outside this module.
    assign rom_o = table_p[addr_i];

    // Four line selectors, one status group picked by Y3..Y2, so that
    // word zero reaches the range and mode lines of group zero.
    assign selected = status_lines_i[{rom_o[3:2], 2'h0} +: 4];

    // Upper bits buffer the ROM; lower bits by Y7 source select.
    always_comb
    begin
        word_o[7:5] = rom_o[6:4];
        word_o[4:1] = rom_o[7] ? rom_o[3:0] : selected;
    end

endmodule
`default_nettype wire

//--- verification/talker_seq_props.sv
// Purpose: Port assertions for the talker output sequencer.
// Assumes: One clock; qualifier delay passed in as a parameter.
// Notes: Delay checks count run lengths instead of long repeats.
`timescale 1ns/1ps
`default_nettype none
module talker_seq_props #(
    parameter int qual_delay_cyc_p = 3
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic power_up_clear_n_i,
    input wire talker_pkg::bus_in_s bus_i,
    input wire talker_pkg::bus_out_s bus_o,
    input wire talker_pkg::seq_in_s seq_i,
    input wire talker_pkg::qual_s qual_o
);
    localparam int lim = qual_delay_cyc_p + 1;
    logic rdy;
    logic acc;
    logic [4:0] on_q;
    logic [4:0] off_q;
    logic [4:0] acc_q;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////
    // Ready as the status generator sees it; accepted gated by the enable as well.
    assign rdy = bus_o.data_oe && bus_i.ready_for_data;
    assign acc = bus_o.data_oe && bus_i.data_accepted;
    // Run lengths saturate so a long idle never wraps to zero.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            on_q <= 5'h00;
            off_q <= 5'h00;
            acc_q <= 5'h00;
        end
        else
        begin
            on_q <= rdy ? on_q + {4'h0, on_q != 5'h1f} : 5'h00;
            off_q <= !rdy ? off_q + {4'h0, off_q != 5'h1f} : 5'h00;
            acc_q <= acc ? acc_q + {4'h0, acc_q != 5'h1f} : 5'h00;
        end
    end
    ////////////////////////////////////////
    sequence s_set_req;
        seq_i.toggle_data_valid_instr && bus_o.data_oe && !bus_o.dav_oe &&
            !qual_o.ready_qualifier_delayed_n &&
            qual_o.accepted_qualifier_delayed_n && power_up_clear_n_i;
    endsequence
    sequence s_long_off;
        off_q > lim && !rdy;
    endsequence
    property p_enable;
        bus_o.data_oe == (!bus_i.talk_addressed_n && !bus_i.bus_attention_in);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable does not follow talk and attention");
    property p_dav_gate;
        bus_o.dav_oe |-> bus_o.data_oe;
    endproperty
    a_dav_gate: assert property (p_dav_gate)
        else $error("DAV driven without enables");
    property p_set;
        s_set_req |=> bus_o.dav_oe || !bus_o.data_oe;
    endproperty
    a_set: assert property (p_set)
        else $error("toggle did not raise DAV");
    property p_clear;
        seq_i.toggle_data_valid_instr && bus_o.dav_oe |=> !bus_o.dav_oe;
    endproperty
    a_clear: assert property (p_clear)
        else $error("toggle did not release DAV");
    property p_puc;
        !power_up_clear_n_i |=> !bus_o.dav_oe;
    endproperty
    a_puc: assert property (p_puc)
        else $error("power-up clear left DAV set");
    property p_done_hold;
        !qual_o.transfer_done_qualifier_n && !seq_i.cycle_start_clear_instr
            |=> !qual_o.transfer_done_qualifier_n;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done dropped without a clear");
    property p_ready_on;
        on_q > lim |-> !qual_o.ready_qualifier_delayed_n;
    endproperty
    a_ready_on: assert property (p_ready_on)
        else $error("ready qualifier not shown");
    property p_ready_off;
        off_q > lim |-> qual_o.ready_qualifier_delayed_n;
    endproperty
    a_ready_off: assert property (p_ready_off)
        else $error("ready qualifier shown while not ready");
    property p_delay;
        s_long_off ##1 rdy |-> qual_o.ready_qualifier_delayed_n [*2];
    endproperty
    a_delay: assert property (p_delay)
        else $error("ready qualifier not delayed");
    property p_accept;
        acc_q > lim |-> !qual_o.accepted_qualifier_delayed_n;
    endproperty
    a_accept: assert property (p_accept)
        else $error("accepted qualifier not shown");
endmodule
bind bus_talker_output_sequencer talker_seq_props #(
    .qual_delay_cyc_p(qual_delay_cyc_p)
) props_inst (.mclk_i, .reset_n_i, .power_up_clear_n_i, .bus_i, .bus_o,
    .seq_i, .qual_o);
`default_nettype wire

//--- verification/talker_listener.sv
// Purpose: Listener model answering the talker handshake.
// Assumes: DAV seen as the talker's pull-down enable.
// Notes: slow_i stretches the accept time so waits are exercised.
`timescale 1ns/1ps
`default_nettype none
module talker_listener (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic dav_oe_i,
    input wire logic slow_i,
    output logic rfd_o,
    output logic dac_o
);
    logic [3:0] wait_q;
    ////////////////////////////////////////
    // Not ready while a word is held; ready again only once DAV is gone,
    // so the talker can never start a word we have not finished.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rfd_o <= 1'b1;
            dac_o <= 1'b0;
            wait_q <= 4'h0;
        end
        else if (dav_oe_i && !dac_o)
        begin
            rfd_o <= 1'b0;
            wait_q <= wait_q + 4'h1;
            dac_o <= wait_q == (slow_i ? 4'hc : 4'h2);
        end
        else if (!dav_oe_i)
        begin
            wait_q <= 4'h0;
            dac_o <= 1'b0;
            rfd_o <= !dac_o;
        end
    end
endmodule
`default_nettype wire

//--- verification/test_bus_talker_output_sequencer.sv
// Purpose: Self-checking bench for the talker output sequencer.
// Assumes: The bench plays the program sequencer and the bus master.
// Notes: A short qualifier delay keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
module test_bus_talker_output_sequencer;
    localparam int dly = 3;
    logic mclk_i, reset_n_i, puc_n, addr_n, atn, rfd, dac, tog, clr, slow;
    logic hsel, hwrite, hready, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] stat;
    talker_pkg::bus_out_s bus_out;
    talker_pkg::qual_s qual_out;
    int err_total, num_checks;
    ////////////////////////////////////////
    bus_talker_output_sequencer #(.qual_delay_cyc_p(dly))
        bus_talker_output_sequencer_inst (.mclk_i, .reset_n_i,
        .power_up_clear_n_i(puc_n),
        .bus_i(talker_pkg::bus_in_s'({addr_n, atn, rfd, dac})),
        .bus_o(bus_out), .seq_i(talker_pkg::seq_in_s'({tog, clr})),
        .qual_o(qual_out), .status_i(talker_pkg::status_lines_s'(stat)),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata));
    talker_listener talker_listener_inst (.mclk_i, .reset_n_i,
        .dav_oe_i(bus_out.dav_oe), .slow_i(slow), .rfd_o(rfd), .dac_o(dac));
    // Free-running 200 MHz clock.
    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    ////////////////////////////////////////
    function automatic logic [31:0] z(input logic b);
        return {31'h0, b};
    endfunction
    task automatic close_out();
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask
    // A hung wait counts as a mismatch and ends the run at once.
    task automatic give_up();
        err_total++;
        close_out();
    endtask
    // One single AHB transfer; read data lands in rd.
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= talker_pkg::htrans_nonseq;
        for (int ph = 0; ph < 2; ph++)
        begin
            n = 0;
            do
            begin
                @(posedge mclk_i);
                n++;
            end
            while (hready !== 1'b1 && n < 20);
            if (n >= 20)
                give_up();
            htrans <= 2'h0;
            hwdata <= wd;
        end
        rd = hrdata;
        check("hresp", z(hresp), 32'h0);
    endtask
    task automatic wait_q(input int b, input logic v);
        int n;
        for (n = 0; n < 200 && qual_out[b] !== v; n++)
            @(posedge mclk_i);
        if (n >= 200)
            give_up();
    endtask
    task automatic pulse(input logic is_tog);
        if (is_tog)
            tog <= 1'b1;
        else
            clr <= 1'b1;
        @(posedge mclk_i);
        tog <= 1'b0;
        clr <= 1'b0;
        @(posedge mclk_i);
    endtask
    // Sends all fourteen words of one bank and checks the done flag.
    task automatic transfer(input logic bank);
        logic [7:0] y;
        logic [31:0] w;
        slow <= bank;
        stat <= ~stat;
        ahb(1'b1, talker_pkg::ctrl_addr, z(bank));
        pulse(1'b0);
        @(posedge mclk_i);
        for (int i = 0; i < 14; i++)
        begin
            wait_q(2, 1'b0);
            wait_q(1, 1'b1);
            y = talker_pkg::char_rom_default[{bank, i[3:0]}];
            w = {25'h0, y[6:4], y[7] ? y[3:0] : stat[{y[3:2], 2'h0} +: 4]};
            check("word", {25'h0, bus_out.data}, w);
            check("done_n", z(qual_out[0]), 32'h1);
            pulse(1'b1);
            check("dav_set", z(bus_out.dav_oe), 32'h1);
            wait_q(1, 1'b0);
            pulse(1'b1);
            check("dav_clr", z(bus_out.dav_oe), 32'h0);
        end
        check("done_n", z(qual_out[0]), 32'h0);
        ahb(1'b0, talker_pkg::status_addr, 32'h0);
        check("count", {28'h0, rd[3:0]}, 32'he);
        check("bank", z(rd[talker_pkg::st_bank_bit]), z(bank));
        repeat (dly + 2) @(posedge mclk_i);
        check("done_n", z(qual_out[0]), 32'h0);
        pulse(1'b0);
        check("done_n", z(qual_out[0]), 32'h1);
    endtask
    ////////////////////////////////////////
    // Main sequence: idle, attention, two banks, power-up clear.
    initial
    begin
        err_total = 0;
        num_checks = 0;
        reset_n_i = 1'b0;
        {puc_n, addr_n, atn, tog, clr, slow} = 6'h30;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        stat = 16'h9c35;
        repeat (5) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        ahb(1'b0, talker_pkg::ctrl_addr, 32'h0);
        check("ctrl", rd, talker_pkg::ctrl_reset);
        ahb(1'b0, 8'h40, 32'h0);
        check("unmapped", rd, 32'h0);
        repeat (dly + 3) @(posedge mclk_i);
        check("oe_idle", z(bus_out.data_oe), 32'h0);
        check("rdy_idle", z(qual_out[2]), 32'h1);
        pulse(1'b1);
        check("dav_idle", z(bus_out.dav_oe), 32'h0);
        addr_n <= 1'b0;
        atn <= 1'b1;
        repeat (dly + 3) @(posedge mclk_i);
        check("oe_atn", z(bus_out.data_oe), 32'h0);
        check("rdy_atn", z(qual_out[2]), 32'h1);
        atn <= 1'b0;
        @(posedge mclk_i);
        check("oe_on", z(bus_out.data_oe), 32'h1);
        transfer(1'b0);
        transfer(1'b1);
        wait_q(2, 1'b0);
        pulse(1'b1);
        puc_n <= 1'b0;
        @(posedge mclk_i);
        puc_n <= 1'b1;
        @(posedge mclk_i);
        check("dav_puc", z(bus_out.dav_oe), 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
